/* cfs_core.sv */
// fetch sequencer core: phases, pipeline, program counter, alu, table reads, bus registers
`timescale 1ns/100ps
module cfs_core (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [12:0] pm_addr_o,
  input  wire logic [15:0] pm_data_i,
  output logic             dm_we_o,
  output logic      [9:0]  dm_addr_o,
  output logic      [7:0]  dm_wdata_o,
  input  wire logic        irq_i,
  output logic             irq_ack_o,
  output logic      [3:0]  phase_o
);
  cfs_pkg::cfs_phase_type phase_ff;
  logic [12:0] pc_ff;
  logic [12:0] pm_addr_ff;
  logic [15:0] ir_ff;
  logic        irv_ff;
  logic        tbl_pend_ff;
  logic [9:0]  tbl_dst_ff;
  logic        tbl_inc_ff;
  logic [7:0]  acc_ff;
  logic [3:0]  flag_ff;
  logic [15:0] tptr_ff;
  logic [7:0]  table_high_result_ff;
  logic [1:0]  ctrl_ff;
  logic        irq_pend_ff;
  logic        irq_ack_ff;
  logic        pclw_pend_ff;
  logic [7:0]  pclw_data_ff;
  logic        dm_we_ff;
  logic [9:0]  dm_addr_ff;
  logic [7:0]  dm_wdata_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic        ph_end;
  logic        exec;
  logic        wb_hit;
  logic        wb_wr;
  logic [2:0]  oc;
  logic [10:0] alu_out;
  logic [3:0]  nxt_flags;
  logic        alu_wr;
  logic        nxt_br;
  logic [12:0] nxt_tgt;
  logic        nxt_push;
  logic        nxt_pop;
  logic        nxt_tbl;
  logic        nxt_irq;
  logic        nxt_pclw;
  logic        nxt_return_from_interrupt;
  logic [12:0] nxt_fetch;
  logic [31:0] nxt_rdata;

  cfs_stk_if sif ();

  cfs_ret_stack u_stack (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sif   (sif)
  );

  // 8-bit alu on accumulator and operand; returns {c, ac, ov, result}
  function automatic logic [10:0] alu_calc(input logic [3:0] op, input logic [7:0] a,
                                           input logic [7:0] b, input logic [3:0] fl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] bb;
    logic       ci;
    logic [7:0] r;
    logic       c;
    logic       ac;
    logic       ov;
    s  = 9'h000;
    h  = 5'h00;
    bb = b;
    ci = 1'b0;
    r  = a;
    c  = fl[cfs_pkg::FLG_C];
    ac = fl[cfs_pkg::FLG_AC];
    ov = fl[cfs_pkg::FLG_OV];
    unique case (cfs_pkg::cfs_alu_type'(op))
      cfs_pkg::ALU_ADD, cfs_pkg::ALU_ADC, cfs_pkg::ALU_SUB, cfs_pkg::ALU_SBC: begin
        // subtraction adds the complement; carry set means no borrow
        bb = (op == cfs_pkg::ALU_SUB || op == cfs_pkg::ALU_SBC) ? ~b : b;
        ci = (op == cfs_pkg::ALU_ADD) ? 1'b0 :
             (op == cfs_pkg::ALU_SUB) ? 1'b1 : fl[cfs_pkg::FLG_C];
        s  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        h  = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        r  = s[7:0];
        c  = s[8];
        ac = h[4];
        ov = (a[7] == bb[7]) && (r[7] != a[7]);
      end
      cfs_pkg::ALU_DAA: begin
        s = {1'b0, a};
        if (a[3:0] > 4'h9 || ac) begin
          s = s + 9'h006;
        end
        if (s[7:4] > 4'h9 || c || s[8]) begin
          s = s + 9'h060;
          c = 1'b1;
        end
        r = s[7:0];
      end
      cfs_pkg::ALU_AND: r = a & b;
      cfs_pkg::ALU_OR:  r = a | b;
      cfs_pkg::ALU_XOR: r = a ^ b;
      cfs_pkg::ALU_CPL: r = ~a;
      cfs_pkg::ALU_RR:  r = {a[0], a[7:1]};
      cfs_pkg::ALU_RRC: begin
        r = {c, a[7:1]};
        c = a[0];
      end
      cfs_pkg::ALU_RL:  r = {a[6:0], a[7]};
      cfs_pkg::ALU_RLC: begin
        r = {a[6:0], c};
        c = a[7];
      end
      cfs_pkg::ALU_INC: r = a + 8'h01;
      cfs_pkg::ALU_DEC: r = a - 8'h01;
      cfs_pkg::ALU_MOV: r = b;
    endcase
    return {c, ac, ov, r};
  endfunction

  // phase sequencer; clearing the run bit freezes the core between phases
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_ff <= cfs_pkg::PH4;
    end else if (ctrl_ff[cfs_pkg::CTRL_RUN]) begin
      unique case (phase_ff)
        cfs_pkg::PH1: phase_ff <= cfs_pkg::PH2;
        cfs_pkg::PH2: phase_ff <= cfs_pkg::PH3;
        cfs_pkg::PH3: phase_ff <= cfs_pkg::PH4;
        cfs_pkg::PH4: phase_ff <= cfs_pkg::PH1;
      endcase
    end
  end

  assign ph_end  = (phase_ff == cfs_pkg::PH4) && ctrl_ff[cfs_pkg::CTRL_RUN];
  assign exec    = irv_ff && !tbl_pend_ff; // dummy and table cycles execute nothing
  assign oc      = cfs_pkg::opclass(ir_ff);
  assign alu_out = alu_calc(ir_ff[12:9], acc_ff, ir_ff[7:0], flag_ff);
  assign alu_wr  = ph_end && exec && (oc == cfs_pkg::OC_ALU || oc == cfs_pkg::OC_SKIP);

  // flag update from the alu result
  always_comb begin
    nxt_flags                  = flag_ff;
    nxt_flags[cfs_pkg::FLG_C]  = alu_out[10];
    nxt_flags[cfs_pkg::FLG_AC] = alu_out[9];
    nxt_flags[cfs_pkg::FLG_OV] = alu_out[8];
    nxt_flags[cfs_pkg::FLG_Z]  = (alu_out[7:0] == 8'h00);
  end

  // flow decisions at the end of each instruction cycle
  always_comb begin
    nxt_br   = 1'b0;
    nxt_tgt  = pc_ff;
    nxt_push = 1'b0;
    nxt_pop  = 1'b0;
    nxt_tbl  = 1'b0;
    nxt_irq  = 1'b0;
    nxt_pclw = 1'b0;
    nxt_return_from_interrupt = 1'b0;
    if (ph_end && exec) begin
      unique case (oc)
        cfs_pkg::OC_ALU: begin
        end
        cfs_pkg::OC_JMP: begin
          nxt_br  = 1'b1;
          nxt_tgt = ir_ff[12:0];
        end
        cfs_pkg::OC_CALL: begin
          nxt_br   = 1'b1; // proceeds even with a full stack
          nxt_tgt  = ir_ff[12:0];
          nxt_push = 1'b1;
        end
        cfs_pkg::OC_RET, cfs_pkg::OC_RETURN_FROM_INTERRUPT: begin
          nxt_br   = 1'b1;
          nxt_tgt  = sif.top_pc;
          nxt_pop  = 1'b1;
          nxt_return_from_interrupt = (oc == cfs_pkg::OC_RETURN_FROM_INTERRUPT);
        end
        cfs_pkg::OC_SKIP: begin
          // refetch at pc drops the word already fetched
          nxt_br  = (alu_out[7:0] == 8'h00);
          nxt_tgt = pc_ff;
        end
        cfs_pkg::OC_TBL: nxt_tbl = 1'b1;
        cfs_pkg::OC_PCL: begin
          nxt_br  = 1'b1; // high bits kept: jump stays in page
          nxt_tgt = {pc_ff[12:8], ir_ff[7:0]};
        end
      endcase
    end
    // bus write to the low byte, then interrupt entry, only in free cycles
    if (ph_end && !tbl_pend_ff && !nxt_br && !nxt_tbl) begin
      if (pclw_pend_ff) begin
        nxt_pclw = 1'b1;
        nxt_br   = 1'b1;
        nxt_tgt  = {pc_ff[12:8], pclw_data_ff};
      end else if (irq_pend_ff && ctrl_ff[cfs_pkg::CTRL_IE] && !sif.full) begin
        nxt_irq  = 1'b1; // a full stack withholds entry
        nxt_br   = 1'b1;
        nxt_tgt  = cfs_pkg::INT_VEC;
        nxt_push = 1'b1;
      end
    end
  end

  assign sif.push    = nxt_push;
  assign sif.pop     = nxt_pop;
  assign sif.push_pc = pm_addr_ff; // address of the word fetched alongside
  assign nxt_fetch   = nxt_br ? nxt_tgt : pc_ff;

  // program counter and fetch address, updated entering the first phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_ff      <= cfs_pkg::RESET_VEC;
      pm_addr_ff <= cfs_pkg::RESET_VEC;
    end else if (ph_end) begin
      if (nxt_tbl) begin
        pm_addr_ff <= tptr_ff[12:0]; // upper pointer bits dropped
      end else begin
        pm_addr_ff <= nxt_fetch;
        pc_ff      <= nxt_fetch + 13'h0001;
      end
    end
  end

  // instruction register; fetch of the next word overlaps execution
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_ff  <= 16'h0000;
      irv_ff <= 1'b0;
    end else if (ph_end && !tbl_pend_ff) begin
      ir_ff  <= pm_data_i;
      irv_ff <= !nxt_br; // discarded word becomes a dummy cycle
    end
  end

  // table read: second cycle fetches the table word, then writes it out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tbl_pend_ff <= 1'b0;
      tbl_dst_ff  <= 10'h000;
      tbl_inc_ff  <= 1'b0;
      table_high_result_ff     <= 8'h00;
      dm_we_ff    <= 1'b0;
      dm_addr_ff  <= 10'h000;
      dm_wdata_ff <= 8'h00;
    end else begin
      dm_we_ff <= 1'b0;
      if (ph_end && nxt_tbl) begin
        tbl_pend_ff <= 1'b1;
        tbl_inc_ff  <= ir_ff[cfs_pkg::TBL_INC_BIT];
        // basic form lands in sector zero
        tbl_dst_ff  <= {ir_ff[cfs_pkg::TBL_EXT_BIT] ? ir_ff[10:9] : 2'h0, ir_ff[7:0]};
      end else if (ph_end && tbl_pend_ff) begin
        tbl_pend_ff <= 1'b0;
        dm_we_ff    <= 1'b1;
        dm_addr_ff  <= tbl_dst_ff;
        dm_wdata_ff <= pm_data_i[7:0];
        table_high_result_ff     <= pm_data_i[15:8];
      end
    end
  end

  // accumulator and status flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff  <= 8'h00;
      flag_ff <= cfs_pkg::FLAG_RESET;
    end else if (alu_wr) begin
      acc_ff  <= alu_out[7:0];
      flag_ff <= nxt_flags;
    end
  end

  // interrupt request is sticky; a new request beats the acknowledge clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_pend_ff <= 1'b0;
      irq_ack_ff  <= 1'b0;
    end else begin
      irq_pend_ff <= irq_i || (irq_pend_ff && !nxt_irq);
      irq_ack_ff  <= nxt_irq;
    end
  end

  assign wb_hit = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wb_wr  = wb_hit && wb_we_i && wb_sel_i[0];

  // control register; entry masks interrupts, return-from-interrupt unmasks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= cfs_pkg::CTRL_RESET;
    end else begin
      if (wb_wr && wb_adr_i == cfs_pkg::REG_CTRL) begin
        ctrl_ff <= wb_dat_i[1:0];
      end
      if (nxt_irq) begin
        ctrl_ff[cfs_pkg::CTRL_IE] <= 1'b0;
      end else if (nxt_return_from_interrupt) begin
        ctrl_ff[cfs_pkg::CTRL_IE] <= 1'b1;
      end
    end
  end

  // low byte write waits for the next free cycle boundary; a newer write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pclw_pend_ff <= 1'b0;
      pclw_data_ff <= 8'h00;
    end else if (wb_wr && wb_adr_i == cfs_pkg::REG_PCL) begin
      pclw_pend_ff <= 1'b1;
      pclw_data_ff <= wb_dat_i[7:0];
    end else if (nxt_pclw) begin
      pclw_pend_ff <= 1'b0;
    end
  end

  // table pointer: low and high bytes by lane, auto-increment after a read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tptr_ff <= 16'h0000;
    end else if (wb_hit && wb_we_i && wb_adr_i == cfs_pkg::REG_TPTR) begin
      if (wb_sel_i[0]) begin
        tptr_ff[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        tptr_ff[15:8] <= wb_dat_i[15:8];
      end
    end else if (ph_end && tbl_pend_ff && tbl_inc_ff) begin
      tptr_ff <= tptr_ff + 16'h0001;
    end
  end

  // read mux; stack state is deliberately absent
  always_comb begin
    unique case (wb_adr_i)
      cfs_pkg::REG_CTRL: nxt_rdata = {30'h0, ctrl_ff};
      cfs_pkg::REG_PCL:  nxt_rdata = {24'h0, pc_ff[7:0]};
      cfs_pkg::REG_STAT: nxt_rdata = {27'h0, irq_pend_ff, flag_ff};
      cfs_pkg::REG_ACC:  nxt_rdata = {24'h0, acc_ff};
      cfs_pkg::REG_TPTR: nxt_rdata = {16'h0, tptr_ff};
      cfs_pkg::REG_TABLE_HIGH_RESULT: nxt_rdata = {24'h0, table_high_result_ff};
      default:           nxt_rdata = 32'h0; // unmapped reads as zero
    endcase
  end

  // one-wait-state slave: ack one edge after the strobe, dropped the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        dat_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o   = ack_ff;
  assign wb_dat_o   = dat_ff;
  assign pm_addr_o  = pm_addr_ff;
  assign dm_we_o    = dm_we_ff;
  assign dm_addr_o  = dm_addr_ff;
  assign dm_wdata_o = dm_wdata_ff;
  assign irq_ack_o  = irq_ack_ff;
  assign phase_o    = phase_ff;

  phase_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph_end |=> phase_ff == cfs_pkg::PH1 && $onehot(phase_ff))
    else $error("phase did not wrap to first phase");
  pc_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph_end && !nxt_br && !nxt_tbl && !tbl_pend_ff
      |=> pm_addr_ff == $past(pc_ff) && pc_ff == $past(pc_ff) + 13'h0001)
    else $error("sequential fetch did not advance pc");
  branch_dummy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph_end && nxt_br |=> !irv_ff && pm_addr_ff == $past(nxt_tgt))
    else $error("branch without dummy cycle or wrong target");
  reset_vec_a: assert property (@(posedge clk_i)
    rst_i |=> pm_addr_ff == 13'h0000 && pc_ff == 13'h0000 && !irv_ff)
    else $error("reset vector not loaded");
  irq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.full && !nxt_pop |=> !irq_ack_o)
    else $error("interrupt acknowledged with full stack");
  tbl_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph_end && nxt_tbl |=> tbl_pend_ff && pm_addr_ff == $past(tptr_ff[12:0])
      && pc_ff == $past(pc_ff))
    else $error("table address not from pointer");
  tbl_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph_end && tbl_pend_ff |=> dm_we_o && table_high_result_ff == $past(pm_data_i[15:8])
      && dm_wdata_o == $past(pm_data_i[7:0]) && !tbl_pend_ff)
    else $error("table word not delivered");
  pcl_page_a: assert property (@(posedge clk_i) disable iff (rst_i)
    nxt_pclw |=> pm_addr_ff == {$past(pc_ff[12:8]), $past(pclw_data_ff)} && !irv_ff)
    else $error("low byte jump left its page");
endmodule // cfs_core

/* cfs_mem_model.sv */
// memory model on the far side of the fetch sequencer
`timescale 1ns/100ps
module cfs_mem_model (
  input  wire logic        clk_i,
  input  wire logic [12:0] pm_addr_i,
  output logic      [15:0] pm_data_o,
  input  wire logic        dm_we_i,
  input  wire logic [9:0]  dm_addr_i,
  input  wire logic [7:0]  dm_wdata_i
);
  logic [15:0] pmem [8192];
  logic [7:0]  dmem [1024];
  // word follows the address, which stands for the whole cycle
  assign pm_data_o = pmem[pm_addr_i];
  // table result byte; sector sits in the top address bits
  always_ff @(posedge clk_i) begin
    if (dm_we_i) dmem[dm_addr_i] <= dm_wdata_i;
  end
endmodule // cfs_mem_model

/* cfs_pkg.sv */
// constants, types and decode helpers for the fetch sequencer core
package cfs_pkg;
  localparam int PC_W = 13;
  localparam int DW = 8;
  localparam int IW = 16;
  localparam int DA_W = 10;
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] INT_VEC = 13'h0004;
  localparam logic [3:0] STK_DEPTH = 4'h8;
  // bus register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PCL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ACC = 8'h0C;
  localparam logic [7:0] REG_TPTR = 8'h10;
  localparam logic [7:0] REG_TABLE_HIGH_RESULT = 8'h14;
  // control bits and reset value
  localparam int CTRL_RUN = 0;
  localparam int CTRL_IE = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // flag positions
  localparam int FLG_C = 0;
  localparam int FLG_AC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam logic [3:0] FLAG_RESET = 4'h0;
  // instruction classes in bits 15:13
  localparam logic [2:0] OC_ALU = 3'h0;
  localparam logic [2:0] OC_JMP = 3'h1;
  localparam logic [2:0] OC_CALL = 3'h2;
  localparam logic [2:0] OC_RET = 3'h3;
  localparam logic [2:0] OC_RETURN_FROM_INTERRUPT = 3'h4;
  localparam logic [2:0] OC_SKIP = 3'h5;
  localparam logic [2:0] OC_TBL = 3'h6;
  localparam logic [2:0] OC_PCL = 3'h7;
  localparam int TBL_INC_BIT = 12;
  localparam int TBL_EXT_BIT = 11;
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_DAA = 4'h4, ALU_AND = 4'h5, ALU_OR = 4'h6, ALU_XOR = 4'h7,
    ALU_CPL = 4'h8, ALU_RR = 4'h9, ALU_RRC = 4'hA, ALU_RL = 4'hB,
    ALU_RLC = 4'hC, ALU_INC = 4'hD, ALU_DEC = 4'hE, ALU_MOV = 4'hF
  } cfs_alu_type;
  typedef enum logic [3:0] {
    PH1 = 4'h1, PH2 = 4'h2, PH3 = 4'h4, PH4 = 4'h8
  } cfs_phase_type;
  function automatic logic [2:0] opclass(input logic [15:0] w);
    return w[15:13];
  endfunction
endpackage

/* cfs_ret_stack.sv */
// eight-level hidden return stack with overwrite on overflow
`timescale 1ns/100ps
module cfs_ret_stack (
  input  wire logic clk_i,
  input  wire logic rst_i,
  cfs_stk_if.stack  sif
);
  logic [12:0] mem_ff [8];
  logic [2:0]  wp_ff;
  logic [3:0]  lvl_ff;

  // circular storage: a push on a full stack overwrites the oldest slot
  always_ff @(posedge clk_i) begin
    if (sif.push) begin
      mem_ff[wp_ff] <= sif.push_pc;
    end
  end

  // write pointer and fill level; no software path reaches either
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_ff  <= 3'h0;
      lvl_ff <= 4'h0;
    end else if (sif.push) begin
      wp_ff <= wp_ff + 3'h1;
      if (lvl_ff != cfs_pkg::STK_DEPTH) begin
        lvl_ff <= lvl_ff + 4'h1; // level saturates on overflow
      end
    end else if (sif.pop && lvl_ff != 4'h0) begin
      wp_ff  <= wp_ff - 3'h1;
      lvl_ff <= lvl_ff - 4'h1;
    end
  end

  assign sif.top_pc = mem_ff[wp_ff - 3'h1];
  assign sif.full   = (lvl_ff == cfs_pkg::STK_DEPTH);

  stk_reset_a: assert property (@(posedge clk_i) rst_i |=> lvl_ff == 4'h0)
    else $error("stack not empty after reset");
  stk_over_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.push && sif.full |=> lvl_ff == 4'h8 && wp_ff == $past(wp_ff) + 3'h1)
    else $error("overflow push mishandled");
  stk_lifo_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sif.push |=> sif.top_pc == $past(sif.push_pc))
    else $error("pushed pc not on top");
endmodule // cfs_ret_stack

/* cfs_stk_if.sv */
// return stack connection between core and stack storage
`timescale 1ns/100ps
interface cfs_stk_if;
  logic        push;
  logic        pop;
  logic [12:0] push_pc;
  logic [12:0] top_pc;
  logic        full;
  modport core  (output push, pop, push_pc, input top_pc, full);
  modport stack (input push, pop, push_pc, output top_pc, full);
endinterface

/* testbench.sv */
// self-checking bench for the fetch sequencer core
`timescale 1ns/100ps
module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, irq = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, q, rdat;
  logic        ack, dm_we, irq_ack, saw_vec = 1'b0;
  logic [12:0] pm_addr, a;
  logic [15:0] pm_data;
  logic [9:0]  dm_addr;
  logic [7:0]  dm_wdata;
  logic [3:0]  phase;
  int          n_mismatch, compares, cycles, acks;
  // program image: address then word
  logic [28:0] prog [19] = '{
    {13'h000, 16'h1E00}, {13'h001, 16'h2000}, {13'h004, 16'h8000}, {13'h005, 16'h4200},
    {13'h006, 16'h00FF}, {13'h007, 16'h0001}, {13'h008, 16'hE040}, {13'h040, 16'h0200},
    {13'h041, 16'h2040}, {13'h050, 16'h0200}, {13'h051, 16'h4050}, {13'h060, 16'h6000},
    {13'h200, 16'hBE00}, {13'h201, 16'h1E55}, {13'h202, 16'hD030}, {13'h203, 16'hCC31},
    {13'h204, 16'h6000}, {13'h1F06, 16'hA51A}, {13'h1F07, 16'h3C5B}};

  cfs_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .pm_addr_o(pm_addr), .pm_data_i(pm_data), .dm_we_o(dm_we),
    .dm_addr_o(dm_addr), .dm_wdata_o(dm_wdata), .irq_i(irq), .irq_ack_o(irq_ack),
    .phase_o(phase));
  cfs_mem_model mem (.clk_i(clk_i), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
    .dm_we_i(dm_we), .dm_addr_i(dm_addr), .dm_wdata_i(dm_wdata));

  // 100 MHz clock
  initial forever #5 clk_i = ~clk_i;

  // cycle ceiling, acknowledge count, vector fetch seen
  always @(posedge clk_i) begin
    cycles++;
    if (irq_ack === 1'b1) acks++;
    if (phase === 4'h1 && pm_addr === 13'h004) saw_vec = 1'b1;
    if (cycles > 5000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic test_done;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one classic cycle; nothing moves until the edge that sees ack
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    chk(ack, 32'h1, "no bus ack");
    r = rdat;
    req <= 1'b0;
    @(posedge clk_i);
  endtask

  // address of the next fetch, taken once phase one has settled
  task automatic fetch(output logic [12:0] f);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (phase !== 4'h1 && n < 8);
    f = pm_addr;
  endtask

  // bounded wait for a given fetch address
  task automatic reach(input logic [12:0] t);
    int n;
    n = 0;
    do begin
      fetch(a);
      n++;
    end while (a !== t && n < 60);
    chk(a, t, "target not fetched");
  endtask

  // request held until acknowledged, then dropped; still high at entry, it stays pending and is taken a second time
  task automatic wait_ack;
    int n;
    n = 0;
    while (irq_ack !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    irq <= 1'b0;
    chk(irq_ack, 32'h1, "no interrupt ack");
  endtask

  // start address, phase order, dummy fetch behind a jump
  task automatic t_start;
    for (int i = 0; i < 5; i++) begin
      fetch(a);
      chk(a, i % 3, "fetch order");
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      #1;
      chk(phase, 32'h2 << i, "phase order");
    end
  endtask

  // page jump by bus, call, skip, table reads, return, carry into adc
  task automatic t_prog;
    wb(1'b0, 8'h1C, 32'h0, 4'h1, q);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, 8'h10, 32'hFF06, 4'h3, q);
    wb(1'b1, 8'h04, 32'h05, 4'h1, q);
    reach(13'h041);
    // the adc beside this fetch retires only at the end of its cycle
    fetch(a);
    wb(1'b0, 8'h0C, 32'h0, 4'h1, q);
    chk(q, 32'h01, "acc");
    wb(1'b0, 8'h08, 32'h0, 4'h1, q);
    chk(q & 32'h1F, 32'h00, "status");
    wb(1'b0, 8'h14, 32'h0, 4'h1, q);
    chk(q, 32'h3C, "table high");
    chk(mem.dmem[10'h030], 32'h1A, "table low");
    chk(mem.dmem[10'h231], 32'h5B, "ext table low");
  endtask

  // interrupt entry through the vector, return re-enables
  task automatic t_irq;
    chk(saw_vec, 32'h0, "early vector");
    wb(1'b1, 8'h00, 32'h3, 4'h1, q);
    irq <= 1'b1;
    wait_ack();
    reach(13'h041);
    chk(saw_vec, 32'h1, "vector fetch");
    wb(1'b0, 8'h00, 32'h0, 4'h1, q);
    chk(q & 32'h3, 32'h3, "enable after return");
  endtask

  // calls past eight levels go on; entry waits until a return frees one
  task automatic t_ovf;
    int n;
    wb(1'b1, 8'h04, 32'h50, 4'h1, q);
    for (int i = 0; i < 10; i++) reach(13'h052);
    @(posedge clk_i);
    irq <= 1'b1;
    n = acks;
    for (int i = 0; i < 4; i++) reach(13'h052);
    chk(acks - n, 32'h0, "ack on full stack");
    wb(1'b0, 8'h08, 32'h0, 4'h1, q);
    chk(q & 32'h10, 32'h10, "pending kept");
    wb(1'b1, 8'h04, 32'h60, 4'h1, q);
    wait_ack();
  endtask

  initial begin
    for (int i = 0; i < 8192; i++) mem.pmem[i] = 16'h0000;
    foreach (prog[i]) mem.pmem[prog[i][28:16]] = prog[i][15:0];
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_start();
    t_prog();
    t_irq();
    t_ovf();
    test_done();
  end
endmodule // testbench
